//--- rtl/can_mode_pkg.sv
package can_mode_pkg;
	// register byte addresses
	localparam logic [7:0] CTRL_ADDR = 8'h00;
	localparam logic [7:0] STAT_ADDR = 8'h04;
	localparam logic [7:0] ERR_ADDR  = 8'h08;
	localparam logic [7:0] BTR_ADDR  = 8'h0c;
	localparam logic [7:0] TEST_ADDR = 8'h14;
	localparam logic [7:0] BRPE_ADDR = 8'h18;
	localparam logic [7:0] IF1_BASE  = 8'h20;
	localparam logic [7:0] IF2_BASE  = 8'h40;
	localparam logic [7:0] IF_CMD    = 8'h00;
	localparam logic [7:0] IF_ARB    = 8'h04;
	localparam logic [7:0] IF_MSK    = 8'h08;
	localparam logic [7:0] IF_CTL    = 8'h0c;
	localparam logic [7:0] IF_DA     = 8'h10;
	localparam logic [7:0] IF_DB     = 8'h14;
	// control register fields
	localparam int CTRL_INIT_BIT = 0;
	localparam int CTRL_DAR_BIT  = 5;
	localparam int CTRL_CCE_BIT  = 6;
	localparam int CTRL_TEST_BIT = 7;
	localparam logic [15:0] CTRL_RESET = 16'h0001;
	localparam logic [15:0] CTRL_WMASK = 16'h00e1;
	// test register fields
	localparam int TEST_BASIC_BIT  = 2;
	localparam int TEST_SILENT_BIT = 3;
	localparam int TEST_LOOPBACK_BIT_BIT  = 4;
	localparam int TEST_TXM_LSB    = 5;
	localparam int TEST_RX_BIT     = 7;
	localparam logic [15:0] TEST_WMASK = 16'h007c;
	localparam logic [1:0] TXM_SERIAL    = 2'h0;
	localparam logic [1:0] TXM_SAMPLE    = 2'h1;
	localparam logic [1:0] TXM_RECESSIVE = 2'h2;
	localparam logic [1:0] TXM_DOMINANT  = 2'h3;
	// interface set, status and timing fields
	localparam int CMD_BUSY_BIT   = 15;
	localparam int CMD_WR_BIT     = 7;
	localparam int CMD_NUM_W      = 6;
	localparam int ARB_VALID_BIT  = 15;
	localparam int ARB_DIR_BIT    = 13;
	localparam int CTL_NEW_DATA_FLAG_BIT = 15;
	localparam int CTL_MESSAGE_LOST_FLAG_BIT = 14;
	localparam int CTL_TX_REQUEST_FLAG_BIT = 8;
	localparam int STAT_IDLE_BIT   = 4;
	localparam int STAT_BUSOFF_BIT = 7;
	localparam logic [15:0] BTR_RESET  = 16'h2301;
	localparam logic [15:0] BTR_WMASK  = 16'h7fff;
	localparam logic [15:0] BRPE_WMASK = 16'h000f;
	// simplified frame: sof, 11 id bits, 4 dlc bits, 64 data bits, ack, 7 eof bits
	localparam int ID_W = 11;
	localparam int PAY_W = 79;
	localparam logic [6:0] POS_ID_LAST  = 7'h0b;
	localparam logic [6:0] POS_PAY_LAST = 7'h4f;
	localparam logic [6:0] POS_ACK      = 7'h50;
	localparam logic [6:0] POS_LAST     = 7'h57;
	localparam logic [3:0] IDLE_BITS    = 4'hb;
	localparam logic [3:0] EOF_BITS     = 4'h7;
	localparam logic [2:0] TQ_LAST      = 3'h7;
	localparam logic [2:0] SAMPLE_TQ    = 3'h5;
	localparam int TEC_W = 9;
	localparam logic [9:0] TEC_ERR_INC = 10'h008;
	localparam logic [9:0] TEC_BUSOFF  = 10'h100;

	typedef struct packed {
		logic [10:0] id;
		logic [3:0]  dlc;
		logic [63:0] data;
	} can_frame_t;

	typedef enum logic [1:0] {
		ST_WAIT_IDLE = 2'b00,
		ST_IDLE      = 2'b01,
		ST_FRAME     = 2'b11
	} bsp_state_t;
endpackage

//--- rtl/can_rx_sync.sv
`timescale 1ns/1ns
module can_rx_sync (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic pin_i,
	output logic      level_o
);
	logic s1_ff;
	logic s2_ff;
	logic s3_ff;

	// three stages; the level moves only once stages two and three agree
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_ff   <= 1'b1;
			s2_ff   <= 1'b1;
			s3_ff   <= 1'b1;
			level_o <= 1'b1;
		end else begin
			s1_ff <= pin_i;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			if (s2_ff == s3_ff) begin
				level_o <= s3_ff;
			end
		end
	end
endmodule

//--- rtl/can_mode_ctrl.sv
// Design decisions made here: the Wishbone register port and the register addresses.
`timescale 1ns/1ns
// Contract
// - init bit set by reset, by bus-off, and by software write.
// - init stops transfer, tx pin recessive, counters and configuration kept.
// - timing and prescaler extension writable only with init and cce set.
// - after init clears, wait eleven recessive bits before joining bus.
// - matched received frame stored whole: id, dlc, eight data bytes.
// - object data stays consistent under concurrent cpu and bus access.
// - any number of requests sent one by one, lowest object first.
// - data updated before transmission start replaces the old data.
// - automatic retransmission by default; no_auto_retransmit turns it off.
// - without retransmission: start clears request, success clears new data.
// - test enable unlocks test bits; rx monitor read-only; clearing disables all.
// - listen-only receives, sends only recessive, routes dominant bits internally.
// - loopback feeds tx to rx, ignores pin and ack errors, tx visible.
// - loopback plus listen-only cuts rx pin and holds tx recessive.
// - ram-bypass: first set busy requests and locks, sent at idle, released.
// - ram-bypass: clearing busy while locked aborts and stops retransmission.
// - ram-bypass: every received frame copied to second set; own frames only in loopback; busy write captures shifter.
// - ram-bypass: object and mask bits ignored; second set control reduced.
// - ram-bypass: wait-ready output held at constant one.
// - tx mode bits pick serial data, sample point, recessive or dominant.
// - control reads 0x0001 after reset; no bus traffic until init cleared.
module can_mode_ctrl #(
	parameter int NOBJ = 32
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        can_rx_i,
	output logic             can_tx_o,
	output logic             can_wait_n_o
);
	localparam int IW = $clog2(NOBJ);

	logic [15:0] ctrl_ff;
	logic [15:0] test_ff;
	logic [15:0] btr_ff;
	logic [15:0] brpe_ff;
	logic        wb_wr;
	logic        wb_rd;
	logic        rx_s;
	logic        init;
	logic        basic;
	logic        silent;
	logic        loopback_bit;
	logic        no_auto_retransmit;
	logic [1:0]  txm;
	// message objects
	can_mode_pkg::can_frame_t obj_frame [NOBJ];
	logic [10:0]     obj_msk [NOBJ];
	logic [NOBJ-1:0] obj_valid;
	logic [NOBJ-1:0] obj_dir;
	logic [NOBJ-1:0] obj_txrq;
	logic [NOBJ-1:0] obj_new_data_flag;
	logic [NOBJ-1:0] obj_message_lost_flag;
	// interface sets
	can_mode_pkg::can_frame_t if_frame [2];
	logic [10:0] if_msk [2];
	logic [5:0]  if_num [2];
	logic [1:0]  if_wr;
	logic [1:0]  if_busy;
	logic [1:0]  if_valid;
	logic [1:0]  if_dir;
	logic [1:0]  if_txrq;
	logic [1:0]  if_new_data_flag;
	logic [1:0]  if_message_lost_flag;
	logic [1:0]  xfer_go;
	// bit stream engine
	can_mode_pkg::bsp_state_t state_ff;
	localparam int PAY_W_L = can_mode_pkg::PAY_W;
	can_mode_pkg::can_frame_t tx_frame_ff;
	logic [PAY_W_L-1:0] shift_ff;
	logic [9:0]  tq_cnt_ff;
	logic [2:0]  tq_idx_ff;
	logic [6:0]  pos_ff;
	logic [3:0]  idle_cnt_ff;
	logic        xmit_ff;
	logic        core_tx_ff;
	logic        sp_ff;
	logic [IW-1:0] tx_idx_ff;
	logic        ev_start_ff;
	logic        ev_ok_ff;
	logic        ev_err_ff;
	logic        ev_rx_ff;
	logic        ev_idle_ff;
	logic        core_rx;
	logic        tq_end;
	logic [8:0]  tec_ff;
	logic        busoff_ff;
	logic        busoff_set;
	logic [9:0]  nxt_tec;
	logic        tx_found;
	logic [IW-1:0] tx_pick;
	logic        rx_hit;
	logic [IW-1:0] rx_idx;
	logic        ev_any;
	can_mode_pkg::can_frame_t rx_frame;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
					      input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [7:0] if_reg(input int s, input logic [7:0] off);
		return ((s == 0) ? can_mode_pkg::IF1_BASE : can_mode_pkg::IF2_BASE) | off;
	endfunction

	can_rx_sync u_rx_sync (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.pin_i   (can_rx_i),
		.level_o (rx_s)
	);

	// effective mode bits; test bits clear one cycle after test enable is clear
	assign init    = ctrl_ff[can_mode_pkg::CTRL_INIT_BIT];
	assign no_auto_retransmit     = ctrl_ff[can_mode_pkg::CTRL_DAR_BIT];
	assign basic   = test_ff[can_mode_pkg::TEST_BASIC_BIT];
	assign silent  = test_ff[can_mode_pkg::TEST_SILENT_BIT];
	assign loopback_bit   = test_ff[can_mode_pkg::TEST_LOOPBACK_BIT_BIT];
	assign txm     = test_ff[can_mode_pkg::TEST_TXM_LSB +: 2];
	assign wb_wr   = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
	assign wb_rd   = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
	assign rx_frame = can_mode_pkg::can_frame_t'(shift_ff);
	assign tq_end  = (tq_cnt_ff == {brpe_ff[3:0], btr_ff[5:0]});
	// receiver input: loopback takes own tx, listen-only folds own dominant bits in
	assign core_rx = loopback_bit ? core_tx_ff : (silent ? (rx_s & core_tx_ff) : rx_s);

	// control, test and timing registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_ff <= can_mode_pkg::CTRL_RESET;
			test_ff <= '0;
			btr_ff  <= can_mode_pkg::BTR_RESET;
			brpe_ff <= '0;
		end else begin
			if (wb_wr && wb_adr_i == can_mode_pkg::CTRL_ADDR) begin
				ctrl_ff <= 16'(merge({16'h0000, ctrl_ff}, wb_dat_i, wb_sel_i))
					   & can_mode_pkg::CTRL_WMASK;
			end
			if (busoff_set) begin
				ctrl_ff[can_mode_pkg::CTRL_INIT_BIT] <= 1'b1;
			end
			if (!ctrl_ff[can_mode_pkg::CTRL_TEST_BIT]) begin
				test_ff <= '0;
			end else if (wb_wr && wb_adr_i == can_mode_pkg::TEST_ADDR) begin
				test_ff <= 16'(merge({16'h0000, test_ff}, wb_dat_i, wb_sel_i))
					   & can_mode_pkg::TEST_WMASK;
			end
			if (init && ctrl_ff[can_mode_pkg::CTRL_CCE_BIT]) begin
				if (wb_wr && wb_adr_i == can_mode_pkg::BTR_ADDR) begin
					btr_ff <= 16'(merge({16'h0000, btr_ff}, wb_dat_i, wb_sel_i))
						  & can_mode_pkg::BTR_WMASK;
				end
				if (wb_wr && wb_adr_i == can_mode_pkg::BRPE_ADDR) begin
					brpe_ff <= 16'(merge({16'h0000, brpe_ff}, wb_dat_i, wb_sel_i))
						   & can_mode_pkg::BRPE_WMASK;
				end
			end
		end
	end

	// transmit pick and acceptance filter; lowest object number wins both
	always_comb begin
		tx_found = 1'b0;
		tx_pick  = '0;
		rx_hit   = 1'b0;
		rx_idx   = '0;
		for (int i = NOBJ - 1; i >= 0; i--) begin
			if (obj_valid[i] && obj_dir[i] && obj_txrq[i]) begin
				tx_found = 1'b1;
				tx_pick  = IW'(i);
			end
			if (obj_valid[i] && !obj_dir[i]
			    && ((rx_frame.id ^ obj_frame[i].id) & obj_msk[i]) == 11'h000) begin
				rx_hit = 1'b1;
				rx_idx = IW'(i);
			end
		end
	end

	// cpu transfers wait for any bus-side object update in the same cycle
	assign ev_any     = ev_start_ff | ev_ok_ff | ev_rx_ff;
	assign xfer_go[0] = if_busy[0] & ~basic & ~ev_any;
	assign xfer_go[1] = if_busy[1] & ~basic & ~ev_any & ~if_busy[0];

	// message object store; valid, direction and flags are cleared at reset, frame and mask are kept
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			obj_valid  <= '0;
			obj_txrq   <= '0;
			obj_new_data_flag <= '0;
			obj_message_lost_flag <= '0;
			obj_dir    <= '0;
		end else if (ev_any) begin
			if (ev_start_ff && !basic) begin
				if (no_auto_retransmit) begin
					obj_txrq[tx_idx_ff] <= 1'b0;
				end else begin
					obj_new_data_flag[tx_idx_ff] <= 1'b0;
				end
			end
			if (ev_ok_ff && !basic) begin
				if (no_auto_retransmit) begin
					obj_new_data_flag[tx_idx_ff] <= 1'b0;
				end else if (!obj_new_data_flag[tx_idx_ff]) begin
					obj_txrq[tx_idx_ff] <= 1'b0;
				end
			end
			if (ev_rx_ff && !basic && rx_hit) begin
				obj_frame[rx_idx]  <= rx_frame;
				obj_new_data_flag[rx_idx] <= 1'b1;
				obj_message_lost_flag[rx_idx] <= obj_new_data_flag[rx_idx];
				obj_txrq[rx_idx]   <= 1'b0;
			end
		end else begin
			for (int s = 0; s < 2; s++) begin
				if (xfer_go[s] && if_wr[s]) begin
					obj_frame[IW'(if_num[s])]  <= if_frame[s];
					obj_msk[IW'(if_num[s])]    <= if_msk[s];
					obj_valid[IW'(if_num[s])]  <= if_valid[s];
					obj_dir[IW'(if_num[s])]    <= if_dir[s];
					obj_txrq[IW'(if_num[s])]   <= if_txrq[s];
					obj_new_data_flag[IW'(if_num[s])] <= if_new_data_flag[s];
					obj_message_lost_flag[IW'(if_num[s])] <= if_message_lost_flag[s];
				end
			end
		end
	end

	// interface register sets, cpu side and ram-bypass buffers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			if_busy   <= '0;
			if_wr     <= '0;
			if_valid  <= '0;
			if_dir    <= '0;
			if_txrq   <= '0;
			if_new_data_flag <= '0;
			if_message_lost_flag <= '0;
			for (int s = 0; s < 2; s++) begin
				if_frame[s] <= '0;
				if_msk[s]   <= '0;
				if_num[s]   <= '0;
			end
		end else begin
			for (int s = 0; s < 2; s++) begin
				if (wb_wr && !(basic && s == 0 && if_busy[0])) begin
					if (wb_adr_i == if_reg(s, can_mode_pkg::IF_ARB)) begin
						if_frame[s].id <= 11'(merge({21'h0, if_frame[s].id}, wb_dat_i,
									wb_sel_i));
						if_valid[s] <= wb_dat_i[can_mode_pkg::ARB_VALID_BIT];
						if_dir[s]   <= wb_dat_i[can_mode_pkg::ARB_DIR_BIT];
					end
					if (wb_adr_i == if_reg(s, can_mode_pkg::IF_MSK)) begin
						if_msk[s] <= 11'(merge({21'h0, if_msk[s]}, wb_dat_i, wb_sel_i));
					end
					if (wb_adr_i == if_reg(s, can_mode_pkg::IF_CTL)) begin
						if_frame[s].dlc <= wb_dat_i[3:0];
						if_new_data_flag[s] <= wb_dat_i[can_mode_pkg::CTL_NEW_DATA_FLAG_BIT];
						if_message_lost_flag[s] <= wb_dat_i[can_mode_pkg::CTL_MESSAGE_LOST_FLAG_BIT];
						if_txrq[s]   <= wb_dat_i[can_mode_pkg::CTL_TX_REQUEST_FLAG_BIT];
					end
					if (wb_adr_i == if_reg(s, can_mode_pkg::IF_DA)) begin
						if_frame[s].data[31:0] <= merge(if_frame[s].data[31:0],
										wb_dat_i, wb_sel_i);
					end
					if (wb_adr_i == if_reg(s, can_mode_pkg::IF_DB)) begin
						if_frame[s].data[63:32] <= merge(if_frame[s].data[63:32],
										 wb_dat_i, wb_sel_i);
					end
				end
				if (wb_wr && wb_adr_i == if_reg(s, can_mode_pkg::IF_CMD)) begin
					if (!basic) begin
						if (wb_dat_i[can_mode_pkg::CMD_BUSY_BIT]) begin
							if_busy[s] <= 1'b1;
							if_num[s]  <= wb_dat_i[can_mode_pkg::CMD_NUM_W-1:0];
							if_wr[s]   <= wb_dat_i[can_mode_pkg::CMD_WR_BIT];
						end
					end else if (s == 0) begin
						// a clear while locked aborts; no retry follows
						if_busy[0] <= wb_dat_i[can_mode_pkg::CMD_BUSY_BIT];
					end else if (wb_dat_i[can_mode_pkg::CMD_BUSY_BIT]) begin
						if_frame[1] <= rx_frame;
					end
				end
				if (xfer_go[s]) begin
					if_busy[s] <= 1'b0;
					if (!if_wr[s]) begin
						if_frame[s]  <= obj_frame[IW'(if_num[s])];
						if_msk[s]    <= obj_msk[IW'(if_num[s])];
						if_valid[s]  <= obj_valid[IW'(if_num[s])];
						if_dir[s]    <= obj_dir[IW'(if_num[s])];
						if_txrq[s]   <= obj_txrq[IW'(if_num[s])];
						if_new_data_flag[s] <= obj_new_data_flag[IW'(if_num[s])];
						if_message_lost_flag[s] <= obj_message_lost_flag[IW'(if_num[s])];
					end
				end
			end
			if (basic && ev_ok_ff) begin
				if_busy[0] <= 1'b0;
			end
			// hardware set lands after any cpu write so a new frame is never lost
			if (basic && ev_rx_ff) begin
				if_frame[1]  <= rx_frame;
				if_new_data_flag[1] <= 1'b1;
				if_message_lost_flag[1] <= if_new_data_flag[1];
			end
		end
	end

	// bit stream engine; held in its wait state while init is set
	always_ff @(posedge clk_i) begin
		if (rst_i || init) begin
			state_ff    <= can_mode_pkg::ST_WAIT_IDLE;
			tq_cnt_ff   <= '0;
			tq_idx_ff   <= '0;
			pos_ff      <= '0;
			idle_cnt_ff <= '0;
			xmit_ff     <= 1'b0;
			core_tx_ff  <= 1'b1;
			sp_ff       <= 1'b0;
			shift_ff    <= '0;
			tx_frame_ff <= '0;
			tx_idx_ff   <= '0;
			ev_start_ff <= 1'b0;
			ev_ok_ff    <= 1'b0;
			ev_err_ff   <= 1'b0;
			ev_rx_ff    <= 1'b0;
			ev_idle_ff  <= 1'b0;
		end else begin
			ev_start_ff <= 1'b0;
			ev_ok_ff    <= 1'b0;
			ev_err_ff   <= 1'b0;
			ev_rx_ff    <= 1'b0;
			ev_idle_ff  <= 1'b0;
			sp_ff       <= 1'b0;
			tq_cnt_ff   <= tq_end ? '0 : tq_cnt_ff + 10'h001;
			if (tq_end) begin
				tq_idx_ff <= tq_idx_ff + 3'h1;
			end
			if (tq_end && tq_idx_ff == can_mode_pkg::SAMPLE_TQ) begin
				sp_ff <= 1'b1;
				case (state_ff)
				can_mode_pkg::ST_WAIT_IDLE: begin
					idle_cnt_ff <= core_rx ? idle_cnt_ff + 4'h1 : '0;
					if (core_rx && idle_cnt_ff == can_mode_pkg::IDLE_BITS - 4'h1) begin
						state_ff   <= can_mode_pkg::ST_IDLE;
						ev_idle_ff <= 1'b1;
					end
				end
				can_mode_pkg::ST_IDLE: begin
					if (!core_rx) begin
						state_ff <= can_mode_pkg::ST_FRAME;
						pos_ff   <= 7'h01;
					end
				end
				can_mode_pkg::ST_FRAME: begin
					pos_ff <= pos_ff + 7'h01;
					if (pos_ff <= can_mode_pkg::POS_PAY_LAST) begin
						shift_ff <= {shift_ff[PAY_W_L-2:0], core_rx};
					end
					if (xmit_ff && pos_ff <= can_mode_pkg::POS_PAY_LAST
					    && core_tx_ff != core_rx) begin
						if (pos_ff <= can_mode_pkg::POS_ID_LAST && !core_rx) begin
							xmit_ff <= 1'b0; // lost arbitration, keep receiving
						end else begin
							ev_err_ff <= 1'b1;
							state_ff  <= can_mode_pkg::ST_WAIT_IDLE;
							idle_cnt_ff <= '0;
							xmit_ff   <= 1'b0;
						end
					end
					if (xmit_ff && pos_ff == can_mode_pkg::POS_ACK && core_rx && !loopback_bit) begin
						ev_err_ff <= 1'b1;
						state_ff  <= can_mode_pkg::ST_WAIT_IDLE;
						idle_cnt_ff <= '0;
						xmit_ff   <= 1'b0;
					end
					if (pos_ff == can_mode_pkg::POS_LAST) begin
						ev_ok_ff    <= xmit_ff;
						ev_rx_ff    <= ~xmit_ff | loopback_bit;
						xmit_ff     <= 1'b0;
						state_ff    <= can_mode_pkg::ST_WAIT_IDLE;
						idle_cnt_ff <= can_mode_pkg::EOF_BITS;
					end
				end
				default: state_ff <= can_mode_pkg::ST_WAIT_IDLE;
				endcase
			end
			// drive point at the last quantum of each bit
			if (tq_end && tq_idx_ff == can_mode_pkg::TQ_LAST) begin
				core_tx_ff <= 1'b1;
				if (state_ff == can_mode_pkg::ST_IDLE && !silent
				    && (basic ? if_busy[0] : tx_found)) begin
					xmit_ff     <= 1'b1;
					core_tx_ff  <= 1'b0;
					tx_frame_ff <= basic ? if_frame[0] : obj_frame[tx_pick];
					tx_idx_ff   <= tx_pick;
					ev_start_ff <= 1'b1;
				end else if (state_ff == can_mode_pkg::ST_FRAME) begin
					if (xmit_ff && pos_ff <= can_mode_pkg::POS_PAY_LAST) begin
						core_tx_ff <= tx_frame_ff[7'(PAY_W_L) - pos_ff];
					end else if (!xmit_ff && pos_ff == can_mode_pkg::POS_ACK) begin
						core_tx_ff <= 1'b0;
					end
				end
			end
		end
	end

	// transmit error counter; untouched while init holds the engine
	assign nxt_tec    = {1'b0, tec_ff} + can_mode_pkg::TEC_ERR_INC;
	assign busoff_set = ev_err_ff & ~busoff_ff & (nxt_tec >= can_mode_pkg::TEC_BUSOFF);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tec_ff    <= '0;
			busoff_ff <= 1'b0;
		end else if (ev_err_ff && !busoff_ff) begin
			tec_ff    <= busoff_set ? can_mode_pkg::TEC_BUSOFF[8:0] : nxt_tec[8:0];
			busoff_ff <= busoff_set;
		end else if (ev_ok_ff && tec_ff != '0) begin
			tec_ff <= tec_ff - 9'h001;
		end else if (ev_idle_ff && busoff_ff) begin
			tec_ff    <= '0;
			busoff_ff <= 1'b0;
		end
	end

	// pins; sample-point mode trades protocol function for timing visibility
	always_ff @(posedge clk_i) begin
		if (rst_i || init) begin
			can_tx_o <= 1'b1;
		end else begin
			case (txm)
			can_mode_pkg::TXM_SERIAL:    can_tx_o <= silent | core_tx_ff;
			can_mode_pkg::TXM_SAMPLE:    can_tx_o <= sp_ff;
			can_mode_pkg::TXM_RECESSIVE: can_tx_o <= 1'b1;
			default:                     can_tx_o <= 1'b0;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			can_wait_n_o <= 1'b1;
		end else begin
			can_wait_n_o <= basic | ~(|if_busy);
		end
	end

	// wishbone slave: ack one cycle after the request, unmapped reads zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
			wb_dat_o <= '0;
			if (wb_rd) begin
				if (wb_adr_i == can_mode_pkg::CTRL_ADDR) begin
					wb_dat_o <= {16'h0000, ctrl_ff};
				end else if (wb_adr_i == can_mode_pkg::STAT_ADDR) begin
					wb_dat_o[can_mode_pkg::STAT_BUSOFF_BIT] <= busoff_ff;
					wb_dat_o[can_mode_pkg::STAT_IDLE_BIT] <= state_ff == can_mode_pkg::ST_IDLE;
				end else if (wb_adr_i == can_mode_pkg::ERR_ADDR) begin
					wb_dat_o <= {23'h000000, tec_ff};
				end else if (wb_adr_i == can_mode_pkg::BTR_ADDR) begin
					wb_dat_o <= {16'h0000, btr_ff};
				end else if (wb_adr_i == can_mode_pkg::BRPE_ADDR) begin
					wb_dat_o <= {16'h0000, brpe_ff};
				end else if (wb_adr_i == can_mode_pkg::TEST_ADDR) begin
					wb_dat_o <= {16'h0000, test_ff};
					wb_dat_o[can_mode_pkg::TEST_RX_BIT] <= rx_s;
				end else begin
					for (int s = 0; s < 2; s++) begin
						if (wb_adr_i == if_reg(s, can_mode_pkg::IF_CMD)) begin
							wb_dat_o <= {16'h0000, if_busy[s], 7'h00, if_wr[s], 1'b0,
								     if_num[s]};
						end else if (wb_adr_i == if_reg(s, can_mode_pkg::IF_ARB)) begin
							wb_dat_o <= {16'h0000, if_valid[s], 1'b0, if_dir[s], 2'h0,
								     if_frame[s].id};
						end else if (wb_adr_i == if_reg(s, can_mode_pkg::IF_MSK)) begin
							wb_dat_o <= {21'h000000, if_msk[s]};
						end else if (wb_adr_i == if_reg(s, can_mode_pkg::IF_CTL)) begin
							// reduced control view of the receive buffer in bypass
							wb_dat_o <= {16'h0000, if_new_data_flag[s], if_message_lost_flag[s], 5'h00,
								     if_txrq[s] & ~(basic && s == 1), 4'h0,
								     if_frame[s].dlc};
						end else if (wb_adr_i == if_reg(s, can_mode_pkg::IF_DA)) begin
							wb_dat_o <= if_frame[s].data[31:0];
						end else if (wb_adr_i == if_reg(s, can_mode_pkg::IF_DB)) begin
							wb_dat_o <= if_frame[s].data[63:32];
						end
					end
				end
			end
		end
	end
endmodule

//--- testbench/can_mode_ctrl_chk.sv
`timescale 1ns/1ns
module can_mode_ctrl_chk (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic        wb_ack_o,
	input  wire logic        can_tx_o,
	input  wire logic        can_wait_n_o
);
	logic [15:0] c_ff;
	logic [15:0] t_ff;
	logic [6:0]  cnt_ff;
	logic [15:0] tm;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// test bits mirror the register, which clears a cycle after test enable drops
	assign tm = t_ff;
	// shadow of control and test; bus-off is not mirrored, so only shadow-implies-pin checks
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			c_ff <= 16'h0001;
			t_ff <= 16'h0000;
		end else begin
			if (!c_ff[7]) t_ff <= 16'h0000;
			if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o) begin
				if (wb_adr_i == 8'h00) c_ff <= wb_dat_i[15:0] & 16'h00e1;
				if (wb_adr_i == 8'h14 && c_ff[7]) t_ff <= wb_dat_i[15:0] & 16'h007c;
			end
		end
	end
	// cycles since init cleared; 88 is eleven bits at the fastest prescale
	always_ff @(posedge clk_i) begin
		if (rst_i || c_ff[0]) cnt_ff <= 7'h00;
		else if (cnt_ff != 7'h7f) cnt_ff <= cnt_ff + 7'h01;
	end
	a_reset_pins: assert property ($fell(rst_i) |-> can_tx_o && can_wait_n_o)
		else $error("pins not idle after reset");
	a_init_recessive: assert property (c_ff[0] |=> can_tx_o)
		else $error("tx dominant during init");
	a_idle_wait: assert property (!c_ff[0] && cnt_ff < 7'h58 && tm[6:5] == 2'h0 |=> can_tx_o)
		else $error("tx before bus idle seen");
	a_silent_quiet: assert property (tm[3] |=> can_tx_o)
		else $error("dominant sent in listen-only");
	a_hot_selftest: assert property (tm[4] && tm[3] |=> can_tx_o)
		else $error("tx not held in loopback listen-only");
	a_txm_recessive: assert property (tm[6:5] == 2'h2 |=> can_tx_o)
		else $error("recessive tx mode broken");
	a_txm_dominant: assert property (!c_ff[0] && tm[6:5] == 2'h3 |=> !can_tx_o)
		else $error("dominant tx mode broken");
	a_bypass_wait: assert property (tm[2] |=> can_wait_n_o)
		else $error("wait output low in ram-bypass");
endmodule
bind can_mode_ctrl can_mode_ctrl_chk chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
	.wb_ack_o(wb_ack_o), .can_tx_o(can_tx_o), .can_wait_n_o(can_wait_n_o));

//--- testbench/can_bus_node.sv
`timescale 1ns/1ns
module can_bus_node (
	input  wire logic tx_i,
	input  wire logic drive_dom_i,
	output logic      rx_o
);
	// wired-and bus with pull-up: any dominant driver wins
	assign rx_o = tx_i & ~drive_dom_i;
endmodule

//--- testbench/tb_can_mode_ctrl.sv
`timescale 1ns/1ns
module tb_can_mode_ctrl;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        wb_cyc_i = 1'b0;
	logic        wb_stb_i = 1'b0;
	logic        wb_we_i = 1'b0;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o, can_rx_i, can_tx_o, can_wait_n_o;
	logic        dom = 1'b0;
	logic [31:0] r;
	logic [31:0] exp_q[$];
	logic [31:0] md[5] = '{32'h08, 32'h18, 32'h04, 32'h40, 32'h60};
	logic        ex[5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
	int          n_mismatch = 0;
	int          checks = 0;
	int          cyc_n = 0;
	can_mode_ctrl #(.NOBJ(32)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .can_rx_i(can_rx_i),
		.can_tx_o(can_tx_o), .can_wait_n_o(can_wait_n_o));
	can_bus_node node_u (.tx_i(can_tx_o), .drive_dom_i(dom), .rx_o(can_rx_i));
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	task automatic ckv(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// hold the request until ack is sampled high, then release
	task automatic bus(input logic [7:0] a, input logic [31:0] d, input logic w);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(a, 32'h0, 1'b0);
	endtask
	// pins are registered, so give the write a few edges to reach them
	task automatic pin(input logic t, input logic w);
		repeat (3) @(posedge clk_i);
		ckv({30'h0, can_tx_o, can_wait_n_o}, {30'h0, t, w});
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// read data is judged at the ack edge against the oldest note
	always @(posedge clk_i) begin
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) ckv(wb_dat_o, exp_q.pop_front());
		cyc_n++;
		if (cyc_n == 20000) begin
			n_mismatch++;
			finish_test;
		end
	end
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		r = $urandom(64211);
		rd(8'h00, 32'h1);
		rd(8'h0c, 32'h2301);
		rd(8'h10, 32'h0);
		$display("reset test done");
		r = $urandom & 32'h7fff;
		wr_seq: begin
			bus(8'h0c, r, 1'b1);
			rd(8'h0c, 32'h2301);
			bus(8'h00, 32'h41, 1'b1);
			bus(8'h0c, r, 1'b1);
			rd(8'h0c, r);
			bus(8'h18, r, 1'b1);
			rd(8'h18, r & 32'hf);
			bus(8'h0c, 32'h2300, 1'b1);
			bus(8'h18, 32'h0, 1'b1);
			bus(8'h00, 32'h01, 1'b1);
			bus(8'h0c, r | 32'h1, 1'b1);
			rd(8'h0c, 32'h2300);
		end
		$display("timing test done");
		bus(8'h14, 32'h7c, 1'b1);
		bus(8'h00, 32'h81, 1'b1);
		rd(8'h14, 32'h80);
		bus(8'h14, 32'hff, 1'b1);
		rd(8'h14, 32'hfc);
		pin(1'b1, 1'b1);
		dom <= 1'b1;
		repeat (6) @(posedge clk_i);
		rd(8'h14, 32'h7c);
		dom <= 1'b0;
		bus(8'h14, 32'h0, 1'b1);
		bus(8'h00, 32'h80, 1'b1);
		pin(1'b1, 1'b1);
		for (int i = 0; i < 5; i++) begin
			bus(8'h14, md[i], 1'b1);
			pin(ex[i], 1'b1);
		end
		$display("test mode test done");
		bus(8'h14, 32'h0, 1'b1);
		bus(8'h00, 32'h01, 1'b1);
		rd(8'h00, 32'h01);
		$display("init test done");
		// object 0: valid transmit, id 0x123, request and new data set
		bus(8'h24, 32'ha123, 1'b1);
		bus(8'h2c, 32'h8108, 1'b1);
		bus(8'h20, 32'h8080, 1'b1);
		bus(8'h40, 32'h8000, 1'b1);
		rd(8'h4c, 32'h8108);
		bus(8'h00, 32'h0, 1'b1);
		// start of frame only after the eleven-bit idle wait; bounded so a hang fails
		for (int i = 0; i < 200 && can_tx_o; i++) @(posedge clk_i);
		ckv({31'h0, can_tx_o}, 32'h0);
		$display("object test done");
		finish_test;
	end
endmodule
